// File: logic/efa_defines.vh
// register map, field positions, reset values and timing counts of the alarm/interrupt block
`ifndef EFA_DEFINES_VH
`define EFA_DEFINES_VH
`define EFA_ADR_W 10
`define EFA_IDX_ALIGN 8'h90
`define EFA_IDX_MAINT 8'h91
`define EFA_IDX_FRM_EN 8'h92
`define EFA_IDX_ALM_EN 8'h93
`define EFA_IDX_FRM_FLG 8'h94
`define EFA_IDX_ALM_FLG 8'h95
`define EFA_IDX_FRM_ST 8'h96
`define EFA_IDX_ALM_ST 8'h97
`define EFA_IDX_MODE 8'ha0
`define EFA_RST_MODE 8'h01
`define EFA_RST_ALIGN 8'h00
`define EFA_RST_MAINT 8'h00
`define EFA_RST_EN 8'h00
`define EFA_B_STD_SEL 0
`define EFA_B_BYPASS 1
`define EFA_B_REFR_CHK 1
`define EFA_B_SIG_EXTRA 5
`define EFA_B_TS16_LEN 4
`define EFA_B_RAI_CRIT 3
`define EFA_B_AIS_CRIT 1
`define EFA_B_EXC_CHK 0
`define EFA_EXC_LIMIT 10'd915
`define EFA_E_HIGH_MIN 10'd990
`define EFA_CFE_SECS 3'd5
`define EFA_RAI_RUN 3'd4
`define EFA_RMAI_RUN 2'd3
`define EFA_AIS_ZEROS 2'd3
`define EFA_AIS_LAST 9'h1ff
`define EFA_SA7_ZEROS 2'd2
`define EFA_CLK_HZ 200000000
`define EFA_SEC_S 1
`define EFA_SEC_CYC (`EFA_SEC_S * `EFA_CLK_HZ)
`define EFA_RED_MS 100
`define EFA_RED_CYC (`EFA_RED_MS * (`EFA_CLK_HZ / 1000))
`define EFA_RAC_MS 10
`define EFA_RAC_CYC (`EFA_RAC_MS * (`EFA_CLK_HZ / 1000))
`endif

// File: logic/efa_flag_bank.v
// bank of sticky event flags, cleared as a group
`timescale 1ns/1ps
`default_nettype none
module efa_flag_bank #(
	parameter W = 8
) (
	input wire i_clk, // system clock
	input wire i_rst, // synchronous, active high
	input wire [W-1:0] i_set, // one-cycle set pulses
	input wire i_clr, // clear all, one cycle
	output wire [W-1:0] o_flags // sticky flags
);
	reg [W-1:0] flag;
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : bit_g
			// a set arriving with the clear survives
			always @(posedge i_clk) begin
				if (i_rst)
					flag[g] <= 1'b0;
				else if (i_set[g])
					flag[g] <= 1'b1;
				else if (i_clr)
					flag[g] <= 1'b0;
			end
		end
	endgenerate
	assign o_flags = flag;
endmodule
`default_nettype wire

// File: logic/efa_hold_timer.v
// persistence filter: output follows its condition once it has held long enough
`timescale 1ns/1ps
`default_nettype none
module efa_hold_timer #(
	parameter SET_CYC = 1,
	parameter CLR_CYC = 1
) (
	input wire i_clk, // system clock
	input wire i_rst, // synchronous, active high
	input wire i_cond, // raw condition
	output reg o_state // filtered state
);
	reg [31:0] cnt;
	wire [31:0] cnt_inc = cnt + 32'h1;
	wire [31:0] target = o_state ? CLR_CYC : SET_CYC;
	always @(posedge i_clk) begin
		if (i_rst) begin
			cnt <= 32'h0;
			o_state <= 1'b0;
		end else if (i_cond == o_state) begin
			cnt <= 32'h0;
		end else if (cnt_inc >= target) begin
			cnt <= 32'h0;
			o_state <= i_cond;
		end else begin
			cnt <= cnt_inc;
		end
	end
endmodule
`default_nettype wire

// File: logic/efa_alarm_irq.v
// receive framer alarm criteria, status, sticky indications and interrupt
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "efa_defines.vh"
// What this block does
// - all-zero slot 16 for 1/2 multiframes flags loss
// - criterion 0: remote alarm follows each A bit
// - criterion 1: four consecutive A=1 set alarm
// - criterion 0: frame loss plus sparse zeros gives AIS
// - criterion 1: two sparse periods set, two dense clear
// - 915 check errors per second, clear on read
// - enabled interwork and frame, sig, check loss changes raise interrupt
// - enabled alignment signal errors raise interrupt
// - enabled alarm status changes raise interrupt
// - zero E bit sets far-block error flag
// - check mismatch sets flag; one event suffices
// - level statuses except hunt, rac, cfe and link_id flag on either transition
// - error flags hold until their register read
// - flags ignore enables; read clears all
// - registers held reset unless E1 and framer used
// - interwork status follows interworking mode
// - frame, signalling, check alignment loss live
// - offline hunt shown as live status
// - A high, E low for 10 ms
// - E high over 990/1000 for 5 seconds
// - two of last three Sa7 bits zero
// - red alarm after 100 ms out-of-frame, both ways
module efa_alarm_irq #(
	parameter SEC_CYC = `EFA_SEC_CYC,
	parameter RED_CYC = `EFA_RED_CYC,
	parameter RAC_CYC = `EFA_RAC_CYC
) (
	input wire I_CLK_SYS, // system clock
	input wire I_RST_N, // synchronous reset, active low
	input wire I_WB_CYC, // wishbone cycle
	input wire I_WB_STB, // wishbone strobe
	input wire I_WB_WE, // wishbone write enable
	input wire [`EFA_ADR_W-1:0] I_WB_ADR, // byte address
	input wire [3:0] I_WB_SEL, // byte lanes
	input wire [31:0] I_WB_DAT, // write data
	output reg [31:0] O_WB_DAT, // read data
	output reg O_WB_ACK, // wishbone acknowledge
	input wire I_FRAME_LOSS, // basic frame alignment lost
	input wire I_SIG_MF_LOSS, // signalling multiframe lost
	input wire I_CHECK_MF_LOSS, // check multiframe lost
	input wire I_INTERWORK, // interworking mode active
	input wire I_OFFLINE_HUNT, // offline framer hunting
	input wire I_ALIGN_MOVE, // alignment position moved, pulse
	input wire I_FRAME_ERR, // frame alignment error, pulse
	input wire I_SIG_MF_ERR, // signalling mf error, pulse
	input wire I_CHECK_MF_ERR, // check mf error, pulse
	input wire I_CHECK_ERR, // check remainder mismatch, pulse
	input wire I_NFAS_STB, // non-alignment frame seen, pulse
	input wire I_A_BIT, // A bit of that frame
	input wire I_SA7_BIT, // Sa7 bit of that frame
	input wire I_E_STB, // E bit (frames 13/15) seen, pulse
	input wire I_E_BIT, // that E bit
	input wire I_Y_STB, // signalling mf Y bit seen, pulse
	input wire I_Y_BIT, // that Y bit
	input wire I_MF_STB, // signalling multiframe end, pulse
	input wire I_TS16_ZERO, // slot 16 was all zero this mf
	input wire I_BIT_STB, // received bit valid, pulse
	input wire I_DATA_BIT, // received bit
	output wire O_IRQ, // interrupt, active high
	output reg O_REFRAME_REQ, // reframe on check errors, pulse
	output reg O_SIG_MF_LOSS_REQ // slot-16 loss request, pulse
);
	reg [7:0] mode;
	reg [7:0] align_opt;
	reg [7:0] maint_opt;
	reg [7:0] frm_en;
	reg [7:0] alm_en;
	wire blk_rst;
	wire [7:0] idx = I_WB_ADR[9:2];
	wire req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
	wire wr = req & I_WB_WE & I_WB_SEL[0];
	wire rd = req & ~I_WB_WE;
	wire [7:0] wd = I_WB_DAT[7:0];

	assign blk_rst = ~I_RST_N | ~mode[`EFA_B_STD_SEL] | mode[`EFA_B_BYPASS];

	// mode register stays outside the held reset so the block can leave it
	always @(posedge I_CLK_SYS) begin
		if (!I_RST_N)
			mode <= `EFA_RST_MODE;
		else if (wr && idx == `EFA_IDX_MODE)
			mode <= wd;
	end

	always @(posedge I_CLK_SYS) begin
		if (blk_rst) begin
			align_opt <= `EFA_RST_ALIGN;
			maint_opt <= `EFA_RST_MAINT;
			frm_en <= `EFA_RST_EN;
			alm_en <= `EFA_RST_EN;
		end else if (wr) begin
			case (idx)
				`EFA_IDX_ALIGN: align_opt <= wd;
				`EFA_IDX_MAINT: maint_opt <= wd;
				`EFA_IDX_FRM_EN: frm_en <= wd;
				`EFA_IDX_ALM_EN: alm_en <= wd;
				default: ;
			endcase
		end
	end

	// live framing status, registered copies of the framer levels
	reg st_iw, st_fl, st_sl, st_cl, st_oh;
	always @(posedge I_CLK_SYS) begin
		if (blk_rst) begin
			st_iw <= 1'b0;
			st_fl <= 1'b0;
			st_sl <= 1'b0;
			st_cl <= 1'b0;
			st_oh <= 1'b0;
		end else begin
			st_iw <= I_INTERWORK;
			st_fl <= I_FRAME_LOSS;
			st_sl <= I_SIG_MF_LOSS;
			st_cl <= I_CHECK_MF_LOSS;
			st_oh <= I_OFFLINE_HUNT;
		end
	end

	// remote alarm and remote multiframe alarm
	reg rai, rmai;
	reg [2:0] a_run;
	reg [1:0] y_run;
	wire [2:0] a_run_inc = (a_run == `EFA_RAI_RUN) ? a_run : a_run + 3'h1;
	wire [1:0] y_run_inc = (y_run == `EFA_RMAI_RUN) ? y_run : y_run + 2'h1;
	always @(posedge I_CLK_SYS) begin
		if (blk_rst) begin
			rai <= 1'b0;
			rmai <= 1'b0;
			a_run <= 3'h0;
			y_run <= 2'h0;
		end else begin
			if (I_NFAS_STB) begin
				if (!I_A_BIT) begin
					a_run <= 3'h0;
					rai <= 1'b0;
				end else begin
					a_run <= a_run_inc;
					if (!maint_opt[`EFA_B_RAI_CRIT])
						rai <= 1'b1;
					else if (a_run_inc == `EFA_RAI_RUN)
						rai <= 1'b1;
				end
			end
			if (I_Y_STB) begin
				y_run <= I_Y_BIT ? y_run_inc : 2'h0;
				rmai <= I_Y_BIT & (y_run_inc == `EFA_RMAI_RUN);
			end
		end
	end

	// ones-density detector over 512-bit periods
	reg ones_detect_value, prev_sparse;
	reg [8:0] bit_cnt;
	reg [1:0] zero_cnt;
	wire zero_hit = I_BIT_STB & ~I_DATA_BIT & (zero_cnt != `EFA_AIS_ZEROS);
	wire [1:0] zero_now = zero_hit ? zero_cnt + 2'h1 : zero_cnt;
	wire sparse = zero_now != `EFA_AIS_ZEROS;
	wire period_end = I_BIT_STB & (bit_cnt == `EFA_AIS_LAST);
	always @(posedge I_CLK_SYS) begin
		if (blk_rst) begin
			ones_detect_value <= 1'b0;
			prev_sparse <= 1'b0;
			bit_cnt <= 9'h0;
			zero_cnt <= 2'h0;
		end else if (period_end) begin
			bit_cnt <= 9'h0;
			zero_cnt <= 2'h0;
			prev_sparse <= sparse;
			if (!maint_opt[`EFA_B_AIS_CRIT])
				ones_detect_value <= sparse & st_fl;
			else if (sparse && prev_sparse)
				ones_detect_value <= 1'b1;
			else if (!sparse && !prev_sparse)
				ones_detect_value <= 1'b0;
		end else begin
			if (I_BIT_STB)
				bit_cnt <= bit_cnt + 9'h1;
			zero_cnt <= zero_now;
		end
	end

	// slot-16 all-zero loss criterion
	reg [1:0] ts16_run;
	wire [1:0] ts16_need = maint_opt[`EFA_B_TS16_LEN] ? 2'h2 : 2'h1;
	wire [1:0] ts16_inc = (ts16_run == 2'h3) ? ts16_run : ts16_run + 2'h1;
	always @(posedge I_CLK_SYS) begin
		if (blk_rst) begin
			ts16_run <= 2'h0;
			O_SIG_MF_LOSS_REQ <= 1'b0;
		end else begin
			O_SIG_MF_LOSS_REQ <= 1'b0;
			if (I_MF_STB) begin
				ts16_run <= I_TS16_ZERO ? ts16_inc : 2'h0;
				if (I_TS16_ZERO && maint_opt[`EFA_B_SIG_EXTRA] && ts16_inc == ts16_need)
					O_SIG_MF_LOSS_REQ <= 1'b1;
			end
		end
	end

	// one-second window: excessive check errors and continuous far errors
	reg [31:0] sec_cnt;
	reg [9:0] chk_cnt;
	reg [9:0] e_high;
	reg [2:0] cfe_run;
	reg exc_set;
	wire sec_tick = (sec_cnt == SEC_CYC - 1);
	wire [9:0] chk_inc = (chk_cnt == 10'h3ff) ? chk_cnt : chk_cnt + 10'h1;
	wire [9:0] e_inc = (e_high == 10'h3ff) ? e_high : e_high + 10'h1;
	wire [9:0] chk_now = I_CHECK_ERR ? chk_inc : chk_cnt;
	wire [9:0] e_now = (I_E_STB & I_E_BIT) ? e_inc : e_high;
	wire cfe = (cfe_run == `EFA_CFE_SECS);
	always @(posedge I_CLK_SYS) begin
		if (blk_rst) begin
			sec_cnt <= 32'h0;
			chk_cnt <= 10'h0;
			e_high <= 10'h0;
			cfe_run <= 3'h0;
			exc_set <= 1'b0;
			O_REFRAME_REQ <= 1'b0;
		end else begin
			exc_set <= 1'b0;
			O_REFRAME_REQ <= 1'b0;
			if (sec_tick) begin
				sec_cnt <= 32'h0;
				chk_cnt <= 10'h0;
				e_high <= 10'h0;
				if (chk_now >= `EFA_EXC_LIMIT) begin
					exc_set <= 1'b1;
					O_REFRAME_REQ <= align_opt[`EFA_B_REFR_CHK];
				end
				if (e_now > `EFA_E_HIGH_MIN) begin
					if (!cfe)
						cfe_run <= cfe_run + 3'h1;
				end else begin
					cfe_run <= 3'h0;
				end
			end else begin
				sec_cnt <= sec_cnt + 32'h1;
				chk_cnt <= chk_now;
				e_high <= e_now;
			end
		end
	end

	// sticky excessive-error bit, cleared by reading its register
	reg exc_chk;
	always @(posedge I_CLK_SYS) begin
		if (blk_rst)
			exc_chk <= 1'b0;
		else if (exc_set)
			exc_chk <= 1'b1;
		else if (rd && idx == `EFA_IDX_MAINT)
			exc_chk <= 1'b0;
	end

	// last A and E bits, Sa7 history
	reg last_a, last_e;
	reg [2:0] sa7_hist;
	always @(posedge I_CLK_SYS) begin
		if (blk_rst) begin
			last_a <= 1'b0;
			last_e <= 1'b1;
			sa7_hist <= 3'h7;
		end else begin
			if (I_NFAS_STB) begin
				last_a <= I_A_BIT;
				sa7_hist <= {sa7_hist[1:0], I_SA7_BIT};
			end
			if (I_E_STB)
				last_e <= I_E_BIT;
		end
	end
	wire [1:0] sa7_zeros = {1'b0, ~sa7_hist[0]} + {1'b0, ~sa7_hist[1]} + {1'b0, ~sa7_hist[2]};
	wire link_id = (sa7_zeros >= `EFA_SA7_ZEROS);

	wire carrier_fail_value, ais, rac;
	efa_hold_timer #(.SET_CYC(RED_CYC), .CLR_CYC(RED_CYC)) u_red (
		.i_clk(I_CLK_SYS),
		.i_rst(blk_rst),
		.i_cond(st_fl),
		.o_state(carrier_fail_value)
	);
	efa_hold_timer #(.SET_CYC(RED_CYC), .CLR_CYC(RED_CYC)) u_ais (
		.i_clk(I_CLK_SYS),
		.i_rst(blk_rst),
		.i_cond(st_fl & ones_detect_value),
		.o_state(ais)
	);
	// drops as soon as either bit changes back
	efa_hold_timer #(.SET_CYC(RAC_CYC), .CLR_CYC(1)) u_rac (
		.i_clk(I_CLK_SYS),
		.i_rst(blk_rst),
		.i_cond(last_a & ~last_e),
		.o_state(rac)
	);

	// change detection on every alarm level and on four framing levels (not hunt, rac, cfe, link_id)
	reg [7:0] frm_q, alm_q;
	wire [7:0] frm_lvl = {st_iw, st_fl, st_sl, st_cl, 4'h0};
	wire [7:0] alm_lvl = {rai, rmai, ones_detect_value, 1'b0, carrier_fail_value, ais, 2'b00};
	wire [7:0] frm_chg = frm_lvl ^ frm_q;
	wire [7:0] alm_chg = alm_lvl ^ alm_q;
	always @(posedge I_CLK_SYS) begin
		if (blk_rst) begin
			frm_q <= 8'h00;
			alm_q <= 8'h00;
		end else begin
			frm_q <= frm_lvl;
			alm_q <= alm_lvl;
		end
	end

	wire [7:0] frm_set = {frm_chg[7:4], I_ALIGN_MOVE, I_FRAME_ERR, I_SIG_MF_ERR, I_CHECK_MF_ERR};
	wire [7:0] alm_set = {alm_chg[7:5], 1'b0, alm_chg[3:2], I_E_STB & ~I_E_BIT, I_CHECK_ERR};
	wire [7:0] frm_flg, alm_flg;
	efa_flag_bank #(.W(8)) u_frm_flg (
		.i_clk(I_CLK_SYS),
		.i_rst(blk_rst),
		.i_set(frm_set),
		.i_clr(rd && idx == `EFA_IDX_FRM_FLG),
		.o_flags(frm_flg)
	);
	efa_flag_bank #(.W(8)) u_alm_flg (
		.i_clk(I_CLK_SYS),
		.i_rst(blk_rst),
		.i_set(alm_set),
		.i_clr(rd && idx == `EFA_IDX_ALM_FLG),
		.o_flags(alm_flg)
	);

	// reserved alarm enable bit 4 has no flag behind it, so it cannot raise anything
	assign O_IRQ = |(frm_flg & frm_en) | |(alm_flg & alm_en);

	reg [7:0] rd_mux;
	always @* begin
		case (idx)
			`EFA_IDX_MODE: rd_mux = mode;
			`EFA_IDX_ALIGN: rd_mux = align_opt;
			`EFA_IDX_MAINT: rd_mux = {maint_opt[7:1], exc_chk};
			`EFA_IDX_FRM_EN: rd_mux = frm_en;
			`EFA_IDX_ALM_EN: rd_mux = alm_en;
			`EFA_IDX_FRM_FLG: rd_mux = frm_flg;
			`EFA_IDX_ALM_FLG: rd_mux = alm_flg;
			`EFA_IDX_FRM_ST: rd_mux = {st_iw, st_fl, st_sl, st_cl, st_oh, rac, cfe, link_id};
			`EFA_IDX_ALM_ST: rd_mux = {rai, rmai, ones_detect_value, 1'b0, carrier_fail_value, ais, 2'b00};
			default: rd_mux = 8'h00;
		endcase
	end

	// one wait state free: ack one edge after the request, then drop
	always @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			O_WB_ACK <= 1'b0;
			O_WB_DAT <= 32'h0;
		end else begin
			O_WB_ACK <= req;
			if (rd)
				O_WB_DAT <= {24'h0, rd_mux};
		end
	end
endmodule
`default_nettype wire

// File: bench/efa_alarm_irq_sva.sv
// port checker for the alarm and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "efa_defines.vh"
module efa_alarm_irq_sva (
	input wire I_CLK_SYS, // clock
	input wire I_RST_N, // reset, active low
	input wire I_WB_CYC, // bus cycle
	input wire I_WB_STB, // bus strobe
	input wire I_WB_WE, // bus write
	input wire [`EFA_ADR_W-1:0] I_WB_ADR, // byte address
	input wire [3:0] I_WB_SEL, // byte lanes
	input wire [31:0] I_WB_DAT, // write data
	input wire O_WB_ACK, // acknowledge
	input wire I_FRAME_LOSS, // frame loss level
	input wire I_FRAME_ERR, // frame error pulse
	input wire I_CHECK_ERR, // check error pulse
	input wire I_E_STB, // E strobe
	input wire I_E_BIT, // E bit
	input wire I_MF_STB, // mf end
	input wire I_TS16_ZERO, // slot 16 all zero
	input wire O_IRQ, // interrupt
	input wire O_REFRAME_REQ, // reframe pulse
	input wire O_SIG_MF_LOSS_REQ // slot-16 loss pulse
);
	wire tk = I_WB_CYC && I_WB_STB && !O_WB_ACK;
	wire wr = tk && I_WB_WE && I_WB_SEL[0];
	reg ok;
	reg [7:0] ef;
	reg [7:0] ea;
	// shadow of the enables, so the interrupt can be tied to its cause
	always @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			ok <= 1'b1;
		end else if (wr && I_WB_ADR[9:2] == `EFA_IDX_MODE) begin
			ok <= I_WB_DAT[1:0] == 2'b01;
		end
		if (!I_RST_N || !ok) begin
			ef <= 8'h00;
			ea <= 8'h00;
		end else if (wr && I_WB_ADR[9:2] == `EFA_IDX_FRM_EN) begin
			ef <= I_WB_DAT[7:0];
		end else if (wr && I_WB_ADR[9:2] == `EFA_IDX_ALM_EN) begin
			ea <= I_WB_DAT[7:0];
		end
	end
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N);
	AST_RST: assert property (disable iff (1'b0) !I_RST_N |=> !O_IRQ && !O_WB_ACK)
		else $error("outputs active after reset");
	AST_ACK: assert property (tk |=> O_WB_ACK)
		else $error("request not acknowledged");
	AST_ACK1: assert property (O_WB_ACK |=> !O_WB_ACK)
		else $error("acknowledge longer than one cycle");
	AST_FERR: assert property (I_FRAME_ERR && ef[2] |=> O_IRQ)
		else $error("frame error raised no interrupt");
	AST_CRC: assert property (I_CHECK_ERR && ea[0] |=> O_IRQ)
		else $error("check error raised no interrupt");
	AST_FEB: assert property (I_E_STB && !I_E_BIT && ea[1] |=> O_IRQ)
		else $error("zero E bit raised no interrupt");
	AST_OOF: assert property ($changed(I_FRAME_LOSS) && ef[6] |-> ##[1:2] O_IRQ)
		else $error("frame loss change raised no interrupt");
	AST_QUIET: assert property (ef == 8'h00 && ea == 8'h00 |-> !O_IRQ)
		else $error("interrupt with all enables off");
	AST_SIG: assert property ($rose(O_SIG_MF_LOSS_REQ) |-> $past(I_MF_STB) && $past(I_TS16_ZERO))
		else $error("slot-16 loss without zero multiframe");
	AST_REFR: assert property (O_REFRAME_REQ |=> !O_REFRAME_REQ)
		else $error("reframe request not a pulse");
endmodule
`default_nettype wire

// File: bench/efa_far_end.sv
// far-end terminal model: drives the framer results of the received stream
`timescale 1ns/1ps
`default_nettype none
module efa_far_end (
	input wire i_clk, // system clock
	output logic [4:0] o_lvl, // interwork, frame, sig, check loss, hunt
	output logic [4:0] o_ev, // align move, frame, sig, check mf err, check err
	output logic [2:0] o_stb, // mf end, E, non-alignment frame
	output logic [3:0] o_dat, // slot-16 zero, E, Sa7, A
	output logic [1:0] o_ys, // Y strobe, Y bit
	output logic [1:0] o_bs // bit strobe, data bit
);
	initial begin
		o_lvl = 5'h00;
		o_ev = 5'h00;
		o_stb = 3'h0;
		o_dat = 4'h0;
		o_ys = 2'h0;
		o_bs = 2'h0;
	end
	task lv(input logic [4:0] v);
		@(posedge i_clk);
		o_lvl <= v;
		repeat (4) @(posedge i_clk);
	endtask
	task hold(input int k, input int n);
		@(posedge i_clk);
		o_ev[k] <= 1'b1;
		repeat (n) @(posedge i_clk);
		o_ev[k] <= 1'b0;
	endtask
	task frm(input int k, input logic [3:0] d, input int n = 1);
		@(posedge i_clk);
		o_stb[k] <= 1'b1;
		o_dat <= d;
		repeat (n) @(posedge i_clk);
		o_stb <= 3'h0;
		o_dat <= ~d; // stale bits must not pass for valid ones
	endtask
	task yb(input logic y);
		@(posedge i_clk);
		o_ys <= {1'b1, y};
		@(posedge i_clk);
		o_ys <= {1'b0, ~y};
	endtask
	// one received bit per clock, n bits of the same value
	task bits(input int n, input logic b);
		@(posedge i_clk);
		o_bs <= {1'b1, b};
		repeat (n) @(posedge i_clk);
		o_bs <= {1'b0, ~b};
	endtask
endmodule
`default_nettype wire

// File: bench/testbench.sv
// testbench: register, alarm and interrupt scenarios
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat, rq;
	logic ack, irq, refr, sml;
	logic [4:0] lvl, ev;
	logic [2:0] fs;
	logic [3:0] fd;
	logic [1:0] ys, bs;
	int error_cnt = 0;
	int n_tests = 0;
	int n_refr = 0;
	int n_sml = 0;
	int k;
	always #2.5 clk = ~clk;
	always @(posedge clk) n_refr += (refr === 1'b1);
	always @(posedge clk) n_sml += (sml === 1'b1);
	// short counts keep the second, red and 10 ms timers within the run
	efa_alarm_irq #(.SEC_CYC(1000), .RED_CYC(50), .RAC_CYC(20)) efa_alarm_irq_i (.I_CLK_SYS(clk),
		.I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hf),
		.I_WB_DAT(wd), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_FRAME_LOSS(lvl[3]), .I_SIG_MF_LOSS(lvl[2]),
		.I_CHECK_MF_LOSS(lvl[1]), .I_INTERWORK(lvl[4]), .I_OFFLINE_HUNT(lvl[0]), .I_ALIGN_MOVE(ev[4]),
		.I_FRAME_ERR(ev[3]), .I_SIG_MF_ERR(ev[2]), .I_CHECK_MF_ERR(ev[1]), .I_CHECK_ERR(ev[0]),
		.I_NFAS_STB(fs[0]), .I_A_BIT(fd[0]), .I_SA7_BIT(fd[1]), .I_E_STB(fs[1]), .I_E_BIT(fd[2]),
		.I_Y_STB(ys[1]), .I_Y_BIT(ys[0]), .I_MF_STB(fs[2]), .I_TS16_ZERO(fd[3]), .I_BIT_STB(bs[1]),
		.I_DATA_BIT(bs[0]), .O_IRQ(irq), .O_REFRAME_REQ(refr), .O_SIG_MF_LOSS_REQ(sml));
	efa_far_end efa_far_end_i (.i_clk(clk), .o_lvl(lvl), .o_ev(ev), .o_stb(fs), .o_dat(fd), .o_ys(ys),
		.o_bs(bs));
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task wb(input logic [7:0] ix, input logic w, input logic [7:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {ix, 2'b00};
		wd <= {24'h0, d};
		n = 0;
		@(posedge clk);
		while (ack !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (ack !== 1'b1) begin
			error_cnt++;
			$display("Error ack expected 1 seen %b", ack);
		end
		rq = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task wr(input logic [7:0] ix, input logic [7:0] d);
		wb(ix, 1'b1, d);
	endtask
	task rd(input logic [7:0] ix, input logic [7:0] e);
		wb(ix, 1'b0, 8'h00);
		chk($sformatf("reg %h", ix), {24'h0, e}, rq);
	endtask
	task print_verdict;
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h92, 8'h00);
		rd(8'h93, 8'h00);
		rd(8'h80, 8'h00);
		wr(8'h92, 8'hff);
		rd(8'h92, 8'hff);
		for (k = 1; k < 5; k++) begin
			efa_far_end_i.hold(k, 1);
			@(negedge clk);
			chk("irq", 1, irq);
			rd(8'h94, 8'h01 << (k - 1));
			rd(8'h94, 8'h00);
			chk("irq", 0, irq);
		end
		efa_far_end_i.hold(3, 1);
		efa_far_end_i.hold(3, 1);
		rd(8'h94, 8'h04);
		efa_far_end_i.lv(5'h1f);
		rd(8'h96, 8'hf8);
		rd(8'h96, 8'hf8);
		rd(8'h94, 8'hf0);
		efa_far_end_i.lv(5'h00);
		rd(8'h96, 8'h00);
		rd(8'h94, 8'hf0);
		efa_far_end_i.lv(5'h08);
		repeat (30) @(posedge clk);
		rd(8'h97, 8'h00);
		repeat (40) @(posedge clk);
		rd(8'h97, 8'h08);
		efa_far_end_i.lv(5'h00);
		repeat (70) @(posedge clk);
		rd(8'h97, 8'h00);
		rd(8'h95, 8'h08);
		rd(8'h94, 8'h40);
		wr(8'h91, 8'h00);
		efa_far_end_i.frm(0, 4'h3);
		rd(8'h97, 8'h80);
		efa_far_end_i.frm(0, 4'h2);
		rd(8'h97, 8'h00);
		wr(8'h91, 8'h08);
		for (k = 0; k < 4; k++) begin
			rd(8'h97, 8'h00);
			efa_far_end_i.frm(0, 4'h3);
		end
		rd(8'h97, 8'h80);
		efa_far_end_i.frm(0, 4'h2);
		rd(8'h97, 8'h00);
		efa_far_end_i.frm(0, 4'h0);
		efa_far_end_i.frm(0, 4'h2);
		rd(8'h96, 8'h00);
		efa_far_end_i.frm(0, 4'h0);
		rd(8'h96, 8'h01);
		efa_far_end_i.yb(1'b1);
		efa_far_end_i.yb(1'b1);
		rd(8'h97, 8'h00);
		efa_far_end_i.yb(1'b1);
		rd(8'h97, 8'h40);
		efa_far_end_i.yb(1'b0);
		rd(8'h97, 8'h00);
		rd(8'h95, 8'hc0);
		wr(8'h93, 8'h03);
		efa_far_end_i.frm(1, 4'h0);
		@(negedge clk);
		chk("irq", 1, irq);
		efa_far_end_i.frm(0, 4'h1);
		repeat (30) @(posedge clk);
		rd(8'h96, 8'h05);
		rd(8'h95, 8'h02);
		chk("irq", 0, irq);
		efa_far_end_i.hold(0, 1);
		@(negedge clk);
		chk("irq", 1, irq);
		rd(8'h95, 8'h01);
		wr(8'h90, 8'h02);
		efa_far_end_i.hold(0, 2000);
		repeat (1100) @(posedge clk);
		rd(8'h91, 8'h09);
		rd(8'h91, 8'h08);
		chk("reframe", 1, n_refr != 0);
		wr(8'h91, 8'h20);
		efa_far_end_i.frm(2, 4'h8);
		efa_far_end_i.frm(2, 4'h0);
		chk("sig loss", 1, n_sml);
		wr(8'h91, 8'h30);
		efa_far_end_i.frm(2, 4'h8);
		efa_far_end_i.frm(2, 4'h8);
		repeat (2) @(posedge clk);
		chk("sig loss", 2, n_sml);
		wr(8'h91, 8'h02);
		efa_far_end_i.bits(512, 1'b1);
		rd(8'h97, 8'h00);
		efa_far_end_i.bits(512, 1'b1);
		rd(8'h97, 8'h20);
		efa_far_end_i.bits(512, 1'b0);
		rd(8'h97, 8'h20);
		efa_far_end_i.bits(512, 1'b0);
		rd(8'h97, 8'h00);
		wr(8'h91, 8'h00);
		efa_far_end_i.lv(5'h08);
		efa_far_end_i.bits(512, 1'b1);
		rd(8'h97, 8'h28);
		efa_far_end_i.bits(512, 1'b0);
		rd(8'h97, 8'h0c);
		efa_far_end_i.lv(5'h00);
		// E held high through more than five one-second windows
		efa_far_end_i.frm(1, 4'h4, 6000);
		rd(8'h96, 8'h03);
		repeat (1100) @(posedge clk);
		rd(8'h96, 8'h01);
		wr(8'ha0, 8'h00);
		rd(8'h92, 8'h00);
		wr(8'ha0, 8'h01);
		rd(8'h92, 8'h00);
		wr(8'h92, 8'h5a);
		wr(8'ha0, 8'h03);
		rd(8'h92, 8'h00);
		rd(8'ha0, 8'h03);
		wr(8'ha0, 8'h01);
		rd(8'h92, 8'h00);
		rd(8'ha0, 8'h01);
		print_verdict;
	end
	initial begin
		#150000;
		error_cnt++;
		$display("Error watchdog expected done seen timeout");
		print_verdict;
	end
endmodule
bind efa_alarm_irq efa_alarm_irq_sva efa_alarm_irq_sva_i (.I_CLK_SYS, .I_RST_N, .I_WB_CYC, .I_WB_STB, .I_WB_WE,
	.I_WB_ADR, .I_WB_SEL, .I_WB_DAT, .O_WB_ACK, .I_FRAME_LOSS, .I_FRAME_ERR, .I_CHECK_ERR, .I_E_STB, .I_E_BIT,
	.I_MF_STB, .I_TS16_ZERO, .O_IRQ, .O_REFRAME_REQ, .O_SIG_MF_LOSS_REQ);
`default_nettype wire
